// File: pkg/pcfi_pkg.sv
package pcfi_pkg;
    // Configuration identifiers and the common parameter header byte.
    localparam logic [7:0] CFG_ID_COUNTER = 8'h51;
    localparam logic [7:0] CFG_ID_COMBINED = 8'h52;
    localparam logic [7:0] PRM_HEADER = 8'h13;
    // Field positions inside the two parameter bytes.
    localparam int LINE_FAULT_BIT = 0;
    localparam int DIR_EN_BIT = 1;
    localparam int FTYPE_LSB = 6;
    localparam int SEL_LSB = 0;
    // Function type codes.
    localparam logic [1:0] FTYPE_COUNTER = 2'h1;
    localparam logic [1:0] FTYPE_COMBINED = 2'h3;
    // Reset values: line fault off, direction off, quotient 1, range 50 Hz.
    localparam logic [7:0] DATA1_RESET = 8'h00;
    localparam logic [7:0] DATA2_RESET = 8'h00;
    localparam logic [1:0] FTYPE_RESET = 2'h1;
    // Highest legal codes of the second byte.
    localparam logic [3:0] QUOT_MAX = 4'h4;
    localparam logic [3:0] RANGE_MAX = 4'h5;
    // Frequency gate time and its cycle count at 250 MHz.
    localparam int CLK_MHZ = 250;
    localparam int GATE_MS = 1000;
    localparam int GATE_CYCLES = GATE_MS * 1000 * CLK_MHZ;
    // Telegram byte sequencer states.
    typedef enum logic [1:0] {
        PCFI_IDLE = 2'b00,
        PCFI_HDR = 2'b01,
        PCFI_D1 = 2'b10,
        PCFI_D2 = 2'b11
    } pcfi_state_t;
endpackage

// File: hw/pcfi_channel.sv
module pcfi_channel #(
    parameter int GATE_CYCLES = pcfi_pkg::GATE_CYCLES,
    parameter int FREQ_W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cfg_valid,
    input wire logic [7:0] cfg_byte,
    input wire logic pulse_in,
    input wire logic dir_in,
    input wire logic wire_break_in,
    input wire logic wire_short_in,
    output logic [31:0] count_out,
    output logic [FREQ_W-1:0] freq_out,
    output logic combined_mode,
    output logic line_fault,
    output logic dir_status,
    output logic prm_error,
    output logic prm_done
);
    logic [7:0] id_reg, d1_reg, data1_reg, data2_reg;
    logic [1:0] ftype_reg;
    pcfi_pkg::pcfi_state_t state_reg;
    logic [2:0] pulse_sync_reg;
    logic [1:0] dir_sync_reg, brk_sync_reg, sht_sync_reg;
    logic [13:0] presc_reg, presc_div;
    logic [31:0] gate_reg;
    logic [FREQ_W-1:0] edges_reg;
    logic pulse_edge;
    logic type_ok;
    logic cfg_load;
    logic count_step;

    // The function type in byte one must match the identifier that opened the
    // telegram; a mismatch is a parameter error and the old settings stay.
    assign type_ok = (id_reg == pcfi_pkg::CFG_ID_COUNTER &&
                      d1_reg[pcfi_pkg::FTYPE_LSB +: 2] == pcfi_pkg::FTYPE_COUNTER) ||
                     (id_reg == pcfi_pkg::CFG_ID_COMBINED &&
                      d1_reg[pcfi_pkg::FTYPE_LSB +: 2] == pcfi_pkg::FTYPE_COMBINED);

    // New settings land on the edge that takes byte two of a good telegram.
    assign cfg_load = cfg_valid && (state_reg == pcfi_pkg::PCFI_D2) && type_ok;

    // Telegram parser: identifier, header, byte one, byte two.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= pcfi_pkg::PCFI_IDLE;
            id_reg <= 8'h00;
            d1_reg <= 8'h00;
            data1_reg <= pcfi_pkg::DATA1_RESET;
            data2_reg <= pcfi_pkg::DATA2_RESET;
            ftype_reg <= pcfi_pkg::FTYPE_RESET;
            prm_error <= 1'b0;
            prm_done <= 1'b0;
        end else begin
            prm_done <= 1'b0;
            if (cfg_valid) begin
                case (state_reg)
                    pcfi_pkg::PCFI_IDLE: begin
                        // A byte other than a known identifier is simply skipped.
                        if (cfg_byte == pcfi_pkg::CFG_ID_COUNTER ||
                            cfg_byte == pcfi_pkg::CFG_ID_COMBINED) begin
                            id_reg <= cfg_byte;
                            state_reg <= pcfi_pkg::PCFI_HDR;
                        end
                    end
                    pcfi_pkg::PCFI_HDR: begin
                        if (cfg_byte == pcfi_pkg::PRM_HEADER) begin
                            state_reg <= pcfi_pkg::PCFI_D1;
                        end else begin
                            prm_error <= 1'b1;
                            prm_done <= 1'b1;
                            state_reg <= pcfi_pkg::PCFI_IDLE;
                        end
                    end
                    pcfi_pkg::PCFI_D1: begin
                        d1_reg <= cfg_byte;
                        state_reg <= pcfi_pkg::PCFI_D2;
                    end
                    pcfi_pkg::PCFI_D2: begin
                        state_reg <= pcfi_pkg::PCFI_IDLE;
                        prm_done <= 1'b1;
                        // Type must match identifier; on error old settings stay.
                        if (type_ok) begin
                            ftype_reg <= d1_reg[pcfi_pkg::FTYPE_LSB +: 2];
                            // Bits 5:2 are reserved for these types, so no damping ramp
                            // can be chosen and values pass undamped.
                            data1_reg <= {6'h00, d1_reg[1:0]};
                            data2_reg <= {4'h0, cfg_byte[3:0]};
                            prm_error <= 1'b0;
                        end else begin
                            prm_error <= 1'b1;
                        end
                    end
                    default: state_reg <= pcfi_pkg::PCFI_IDLE;
                endcase
            end
        end
    end

    // Field pins are asynchronous, so each passes two flops first.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_sync_reg <= 3'h0;
            dir_sync_reg <= 2'h0;
            brk_sync_reg <= 2'h0;
            sht_sync_reg <= 2'h0;
        end else begin
            pulse_sync_reg <= {pulse_sync_reg[1:0], pulse_in};
            dir_sync_reg <= {dir_sync_reg[0], dir_in};
            brk_sync_reg <= {brk_sync_reg[0], wire_break_in};
            sht_sync_reg <= {sht_sync_reg[0], wire_short_in};
        end
    end

    assign pulse_edge = pulse_sync_reg[1] & ~pulse_sync_reg[2];

    // Quotient decode; codes above four fall back to counting every pulse.
    always_comb begin
        case (data2_reg[3:0])
            4'h1: presc_div = 14'd10;
            4'h2: presc_div = 14'd100;
            4'h3: presc_div = 14'd1000;
            4'h4: presc_div = 14'd10000;
            default: presc_div = 14'd1;
        endcase
    end

    // A pulse is counted when the prescaler reaches the divisor. The combined
    // mode always counts every pulse, because its second byte carries the range
    // instead of a quotient.
    assign count_step = pulse_edge &&
                        (ftype_reg == pcfi_pkg::FTYPE_COMBINED ||
                         presc_reg + 14'd1 >= presc_div);

    // Prescaler. It restarts at zero when new settings land, so a smaller
    // quotient never inherits a partial count that already lies past its
    // divisor; a pulse in that very cycle steps the main count by the old divisor and the old function type.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_reg <= 14'h0000;
        end else if (cfg_load) begin
            presc_reg <= 14'h0000;
        end else if (pulse_edge) begin
            if (count_step) begin
                presc_reg <= 14'h0000;
            end else begin
                presc_reg <= presc_reg + 14'd1;
            end
        end
    end

    // Main counter: one step for each counted pulse.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_out <= 32'h0000_0000;
        end else if (count_step) begin
            // Direction high subtracts only when detection is on.
            if (data1_reg[pcfi_pkg::DIR_EN_BIT] && dir_sync_reg[1]) begin
                count_out <= count_out - 32'h0000_0001;
            end else begin
                count_out <= count_out + 32'h0000_0001;
            end
        end
    end

    // Status outputs: direction status, line fault flag and combined mode flag.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_status <= 1'b0;
            line_fault <= 1'b0;
            combined_mode <= 1'b0;
        end else begin
            dir_status <= data1_reg[pcfi_pkg::DIR_EN_BIT] & dir_sync_reg[1];
            line_fault <= data1_reg[pcfi_pkg::LINE_FAULT_BIT] &
                          (brk_sync_reg[1] | sht_sync_reg[1]);
            combined_mode <= (ftype_reg == pcfi_pkg::FTYPE_COMBINED);
        end
    end

    // Frequency meter: edges in a one-second gate give Hz directly. A gate this
    // long suits the low ranges; freq is clipped to the selected full-scale.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gate_reg <= 32'h0000_0000;
            edges_reg <= '0;
            freq_out <= '0;
        end else if (ftype_reg != pcfi_pkg::FTYPE_COMBINED) begin
            gate_reg <= 32'h0000_0000;
            edges_reg <= '0;
            freq_out <= '0;
        end else if (gate_reg >= 32'(GATE_CYCLES - 1)) begin
            gate_reg <= 32'h0000_0000;
            // An edge in the closing cycle opens the next gate, so none is lost.
            edges_reg <= pulse_edge ? FREQ_W'(1) : '0;
            freq_out <= (edges_reg > fscale(data2_reg[3:0])) ?
                        fscale(data2_reg[3:0]) : edges_reg;
        end else begin
            gate_reg <= gate_reg + 32'h0000_0001;
            if (pulse_edge && edges_reg != '1) begin
                edges_reg <= edges_reg + FREQ_W'(1);
            end
        end
    end

    // Full-scale in Hz for each range code; unknown codes use 50 Hz.
    function automatic logic [FREQ_W-1:0] fscale(input logic [3:0] code);
        case (code)
            4'h1: fscale = FREQ_W'(20);
            4'h2: fscale = FREQ_W'(10);
            4'h3: fscale = FREQ_W'(5);
            4'h4: fscale = FREQ_W'(2);
            4'h5: fscale = FREQ_W'(1);
            default: fscale = FREQ_W'(50);
        endcase
    endfunction

    // A counted step goes down only with detection on and the direction input high.
    a_dir_down: assert property (@(posedge clk) disable iff (!rst_n)
        count_step && data1_reg[pcfi_pkg::DIR_EN_BIT] && dir_sync_reg[1]
        |=> count_out == $past(count_out) - 32'h0000_0001)
        else $error("count did not decrement");

    // Every other counted step goes up, including all steps with detection off.
    a_dir_up: assert property (@(posedge clk) disable iff (!rst_n)
        count_step && !(data1_reg[pcfi_pkg::DIR_EN_BIT] && dir_sync_reg[1])
        |=> count_out == $past(count_out) + 32'h0000_0001)
        else $error("count did not increment");

    a_no_pulse_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !count_step |=> $stable(count_out))
        else $error("count moved without a counted pulse");

    // The prescaler never reaches its divisor; new settings restart it at zero.
    a_presc_bound: assert property (@(posedge clk) disable iff (!rst_n)
        presc_reg < presc_div)
        else $error("prescaler past divisor");

    // Pulses short of the divisor only advance the prescaler.
    a_quot_step: assert property (@(posedge clk) disable iff (!rst_n)
        pulse_edge && !count_step && !cfg_load
        |=> presc_reg == $past(presc_reg) + 14'd1)
        else $error("prescaler did not advance");

    a_fault_gate: assert property (@(posedge clk) disable iff (!rst_n)
        !data1_reg[pcfi_pkg::LINE_FAULT_BIT] && $stable(data1_reg) |=> !line_fault)
        else $error("line fault with monitoring off");

    // A reported break or short must raise the flag while monitoring is on.
    a_fault_set: assert property (@(posedge clk) disable iff (!rst_n)
        data1_reg[pcfi_pkg::LINE_FAULT_BIT] && (brk_sync_reg[1] || sht_sync_reg[1])
        |=> line_fault)
        else $error("line fault not flagged");

    a_dir_status: assert property (@(posedge clk) disable iff (!rst_n)
        !data1_reg[pcfi_pkg::DIR_EN_BIT] && $stable(data1_reg) |=> !dir_status)
        else $error("direction status with detection off");

    sequence s_bad_hdr;
        cfg_valid && state_reg == pcfi_pkg::PCFI_HDR && cfg_byte != pcfi_pkg::PRM_HEADER;
    endsequence
    a_bad_header: assert property (@(posedge clk) disable iff (!rst_n)
        s_bad_hdr |=> prm_error && prm_done)
        else $error("bad header not flagged");

    sequence s_last_byte;
        cfg_valid && state_reg == pcfi_pkg::PCFI_D2;
    endsequence
    a_type_check: assert property (@(posedge clk) disable iff (!rst_n)
        s_last_byte ##0 (id_reg == pcfi_pkg::CFG_ID_COUNTER &&
        d1_reg[7:6] != pcfi_pkg::FTYPE_COUNTER) |=> prm_error ##1 !prm_done)
        else $error("type mismatch not flagged");

    // An accepted telegram completes cleanly and carries its function type over.
    a_cfg_apply: assert property (@(posedge clk) disable iff (!rst_n)
        s_last_byte ##0 type_ok |=> prm_done && !prm_error &&
        ftype_reg == $past(d1_reg[pcfi_pkg::FTYPE_LSB +: 2]))
        else $error("accepted settings not applied");

    // A telegram needs at least two more bytes, so completion is a one-cycle strobe.
    a_done_strobe: assert property (@(posedge clk) disable iff (!rst_n)
        prm_done |=> !prm_done)
        else $error("completion strobe longer than one cycle");

    a_mode_flag: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> combined_mode == $past(ftype_reg == pcfi_pkg::FTYPE_COMBINED))
        else $error("combined mode flag does not follow the function type");

    // Outside combined mode the frequency reading stays at zero.
    a_freq_idle: assert property (@(posedge clk) disable iff (!rst_n)
        ftype_reg != pcfi_pkg::FTYPE_COMBINED |=> freq_out == '0)
        else $error("frequency reported outside combined mode");

    a_gate_bound: assert property (@(posedge clk) disable iff (!rst_n)
        gate_reg < 32'(GATE_CYCLES))
        else $error("gate counter past its length");

    a_freq_scale: assert property (@(posedge clk) disable iff (!rst_n)
        freq_out <= FREQ_W'(50))
        else $error("frequency above full-scale");
endmodule

// File: tb/pcfi_master.sv
// Far-side master: sends parameter telegrams and watches the running count.
module pcfi_master (
    input wire logic clk,
    input wire logic [31:0] count_out,
    output logic cfg_valid,
    output logic [7:0] cfg_byte,
    output logic count_fell
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] last_count;

    // Idle bus until the first telegram.
    initial begin
        cfg_valid = 1'b0;
        cfg_byte = 8'h00;
        last_count = 32'h0000_0000;
        count_fell = 1'b0;
    end

    // Identifier, header and both data bytes go out back to back, one per edge.
    task automatic send(input logic [7:0] id, input logic [7:0] hdr,
                        input logic [7:0] d1, input logic [7:0] d2);
        logic [7:0] seq [4];
        seq = '{id, hdr, d1, d2};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) #1;
            cfg_valid = 1'b1;
            cfg_byte = seq[i];
        end
        @(posedge clk) #1;
        cfg_valid = 1'b0;
        cfg_byte = ~cfg_byte; // A released bus must not keep showing the last byte.
    endtask

    // No direction bit is sent, so the direction is read from two successive counts.
    task automatic sample();
        count_fell = (count_out < last_count);
        last_count = count_out;
    endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench for one pulse counter and frequency channel.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pulse_in = 1'b0;
    logic dir_in = 1'b0;
    logic wire_break_in = 1'b0;
    logic wire_short_in = 1'b0;
    logic cfg_valid, combined_mode, line_fault, dir_status, prm_error, prm_done, count_fell;
    logic [7:0] cfg_byte;
    logic [31:0] count_out, c0;
    logic [15:0] freq_out;
    int err_total = 0;
    int total_checks = 0;
    int fs [6] = '{50, 20, 10, 5, 2, 1};
    int div [5] = '{1, 10, 100, 1000, 10000};

    // A short gate keeps frequency runs brief; expectations assume 100 cycles.
    pcfi_channel #(.GATE_CYCLES(100), .FREQ_W(16)) dut_u (.clk(clk), .rst_n(rst_n),
        .cfg_valid(cfg_valid), .cfg_byte(cfg_byte), .pulse_in(pulse_in), .dir_in(dir_in),
        .wire_break_in(wire_break_in), .wire_short_in(wire_short_in), .count_out(count_out),
        .freq_out(freq_out), .combined_mode(combined_mode), .line_fault(line_fault),
        .dir_status(dir_status), .prm_error(prm_error), .prm_done(prm_done));

    pcfi_master master_u (.clk(clk), .count_out(count_out), .cfg_valid(cfg_valid),
        .cfg_byte(cfg_byte), .count_fell(count_fell));

    // Clock of 4 ns period.
    initial begin
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
    endtask

    // Lets the synchronisers and output registers catch up.
    task automatic settle();
        repeat (8) @(posedge clk);
        #1;
    endtask

    // One rising edge every two cycles, which is 50 edges per gate.
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk) #1 pulse_in = 1'b1;
            @(posedge clk) #1 pulse_in = 1'b0;
        end
    endtask

    task automatic cfg(input logic [7:0] id, input logic [7:0] d1, input logic [7:0] d2);
        int n;
        n = 0;
        master_u.send(id, pcfi_pkg::PRM_HEADER, d1, d2);
        while (prm_done !== 1'b1 && n < 8) begin
            @(posedge clk) #1;
            n++;
        end
        check(n < 8, 1);
        settle();
    endtask

    // A hang is cut short well past the expected run of about 50,000 cycles.
    initial begin
        #300_000;
        err_total++;
        summarize();
    end

    // Main sequence.
    initial begin
        do_reset();
        wire_break_in = 1'b1;
        dir_in = 1'b1;
        pulses(3);
        settle();
        check(count_out, 3);
        check(line_fault, 0);
        check(combined_mode, 0);
        check(freq_out, 0);
        cfg(pcfi_pkg::CFG_ID_COUNTER, 8'h41, 8'h00);
        check(line_fault, 1);
        wire_break_in = 1'b0;
        wire_short_in = 1'b1;
        settle();
        check(line_fault, 1);
        cfg(pcfi_pkg::CFG_ID_COUNTER, 8'h40, 8'h00);
        check(line_fault, 0);
        wire_short_in = 1'b0;
        cfg(pcfi_pkg::CFG_ID_COUNTER, 8'hC0, 8'h00);
        check(prm_error, 1);
        check(combined_mode, 0);
        master_u.send(pcfi_pkg::CFG_ID_COMBINED, 8'h14, 8'hC0, 8'h00);
        settle();
        check(prm_error, 1);
        check(combined_mode, 0);
        cfg(pcfi_pkg::CFG_ID_COUNTER, 8'h7C, 8'hF0);
        check(prm_error, 0);
        c0 = count_out;
        pulses(4);
        settle();
        check(count_out, c0 + 4);
        // Up then down with direction enabled.
        do_reset();
        cfg(pcfi_pkg::CFG_ID_COUNTER, 8'h42, 8'h00);
        dir_in = 1'b0;
        pulses(5);
        settle();
        master_u.sample();
        dir_in = 1'b1;
        pulses(2);
        settle();
        master_u.sample();
        check(count_out, 3);
        check(dir_status, 1);
        check(count_fell, 1);
        dir_in = 1'b0;
        // Each quotient is tried one pulse short of the second step, then on it.
        for (int q = 0; q < 5; q++) begin
            do_reset();
            cfg(pcfi_pkg::CFG_ID_COUNTER, 8'h40, 8'(q));
            pulses(2 * div[q] - 1);
            settle();
            check(count_out, 1);
            pulses(1);
            settle();
            check(count_out, 2);
        end
        // Combined mode at 50 edges per gate, clipped by each full-scale.
        do_reset();
        for (int r = 0; r < 6; r++) begin
            cfg(pcfi_pkg::CFG_ID_COMBINED, 8'hC0, 8'(r));
            check(combined_mode, 1);
            pulses(150);
            check(freq_out, fs[r]);
        end
        settle();
        check(count_out, 900);
        summarize();
    end
endmodule
